/* File: hdl/sys_timers_params.svh */
`ifndef SYS_TIMERS_PARAMS_SVH
`define SYS_TIMERS_PARAMS_SVH

// ============================================================
// Register addresses
`define ADR_T4_LOW    16'h00ac
`define ADR_T4_HIGH   16'h00ad
`define ADR_T3_LOW    16'h00ae
`define ADR_T3_HIGH   16'h00af
`define ADR_T2_CTRL   16'h00c8
`define ADR_T2_DIV    16'h00c9
`define ADR_T2_RLD_LO 16'h00ca
`define ADR_T2_RLD_HI 16'h00cb
`define ADR_T2_LOW    16'h00cc
`define ADR_T2_HIGH   16'h00cd
`define ADR_T34_CTRL  16'h00cf
`define ADR_T5_CTRL   16'ha003
`define ADR_T5_LOW    16'ha004
`define ADR_T5_MID    16'ha005
`define ADR_T5_TOP    16'ha006

// ============================================================
// Field positions
`define T2_TF    7
`define T2_EXF   6
`define T2_RCLK  5
`define T2_SERIAL_TX_CLOCK_SELECT  4
`define T2_EXEN  3
`define T2_TR    2
`define T2_CT    1
`define T2_CPRL  0
`define T2_DIVB  0
`define T34_TF   3
`define T34_TM   2
`define T34_TR   1
`define T34_IEN  0
`define T34_T4   4
`define T5_TF    7
`define T5_SELH  6
`define T5_TM    4
`define T5_TR    3
`define T5_IEN   0
`define T5_MASK  8'hf9

// ============================================================
// Reset values and timing counts
`define RST_BYTE   8'h00
`define RST_CNT16  16'h0000
`define RST_CNT24  24'h00_0000
`define T2_DIV_SLOW 4'hc
`define T2_DIV_FAST 4'h4

`endif

/* File: hdl/sys_timers_pkg.sv */
package sys_timers_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [1:0] {
        T2_STOPPED,
        T2_RELOAD,
        T2_CAPTURE,
        T2_BAUD
    } t2_mode_e;

endpackage : sys_timers_pkg

/* File: hdl/sys_timers.sv */
// Notes on behaviour
// - Timer 2 trigger events ignored while trigger enable is clear.
// - Reload mode: 16-bit count, overflow sets flag and reloads.
// - Capture mode: overflow sets flag; trigger fall captures count.
// - Either serial clock select forces baud mode with reload on overflow.
// - Timer 2 overflow flag not set in baud mode; software clears it.
// - Receive clock from timer 2 overflow when 1, timer 1 when 0.
// - Transmit clock from timer 2 overflow when 1, timer 1 when 0.
// - Edge flag set on trigger fall when enabled; software clears it.
// - Counter select 1 counts event pin, 0 counts internal clock.
// - Timers 3 and 4 are 16-bit, free-run or auto-reload by mode.
// - Timers 3 and 4 count only while their run bit is set.
// - Timers 3 and 4 overflow set sticky flags cleared by software.
// - Per-timer enable gates timers 3, 4, 5 interrupt requests.
// - Timer 3/4 byte writes hit reload or counter by mode.
// - Count reads return the live counter; read high byte first.
// - Timer 5 is 24-bit, free-run or auto-reload by mode.
// - Timer 5 select 00/01 fast oscillator, 10/11 slow oscillator.
// - Timer 5 counts rising edges of its oscillator, sampled on the core clock.
// - Timer 5 counts only when running; overflow sets sticky flag.
// - Timer 5 byte writes hit reload or counter by mode.
// - Internal timer 2 ticks every 12 clocks, or 4 with divider set.
// - Event pin sampled each clock; count on each falling edge.
`timescale 1ns/1ps
`include "sys_timers_params.svh"

module sys_timers #(
    parameter int ADDR_W = 16
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic [ADDR_W-1:0]     addr_i,
    input  wire sys_timers_pkg::byte_t wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output sys_timers_pkg::byte_t      rdata_o,
    input  wire logic                  timer2_event_pin_i,
    input  wire logic                  timer2_trigger_input_i,
    input  wire logic                  fast_osc_i,
    input  wire logic                  slow_osc_i,
    input  wire logic                  timer1_ovf_i,
    output logic                       serial_rx_clk_o,
    output logic                       serial_tx_clk_o,
    output logic                       timer2_ovf_o,
    output logic                       timer2_irq_o,
    output logic                       timer3_irq_o,
    output logic                       timer4_irq_o,
    output logic                       timer5_irq_o
);
    import sys_timers_pkg::*;

    // ============================================================
    // Helpers
    function automatic logic [23:0] next_count(
        input logic [23:0] cnt,
        input logic [23:0] rld,
        input logic        reload,
        input logic [23:0] top
    );
        if (cnt == top) begin
            next_count = reload ? rld : `RST_CNT24;
        end else begin
            next_count = cnt + 24'h00_0001;
        end
    endfunction : next_count

    // ============================================================
    // Input synchronisers: event, trigger, fast osc, slow osc
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
        end else begin
            sync1_reg <= {slow_osc_i, fast_osc_i,
                          timer2_trigger_input_i, timer2_event_pin_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    logic ev_fall;
    logic trig_fall;
    logic fast_rise;
    logic slow_rise;
    assign ev_fall   = sync3_reg[0] & ~sync2_reg[0];
    assign trig_fall = sync3_reg[1] & ~sync2_reg[1];
    assign fast_rise = sync2_reg[2] & ~sync3_reg[2];
    assign slow_rise = sync2_reg[3] & ~sync3_reg[3];

    // ============================================================
    // Write decode
    logic wr_t2_ctrl;
    logic wr_t2_div;
    logic wr_t2_lo;
    logic wr_t2_hi;
    logic wr_t2_rlo;
    logic wr_t2_rhi;
    logic wr_t34_ctrl;
    logic wr_t5_ctrl;
    logic wr_t5_lo;
    logic wr_t5_mid;
    logic wr_t5_top;
    assign wr_t2_ctrl  = wr_i && addr_i == `ADR_T2_CTRL;
    assign wr_t2_div   = wr_i && addr_i == `ADR_T2_DIV;
    assign wr_t2_lo    = wr_i && addr_i == `ADR_T2_LOW;
    assign wr_t2_hi    = wr_i && addr_i == `ADR_T2_HIGH;
    assign wr_t2_rlo   = wr_i && addr_i == `ADR_T2_RLD_LO;
    assign wr_t2_rhi   = wr_i && addr_i == `ADR_T2_RLD_HI;
    assign wr_t34_ctrl = wr_i && addr_i == `ADR_T34_CTRL;
    assign wr_t5_ctrl  = wr_i && addr_i == `ADR_T5_CTRL;
    assign wr_t5_lo    = wr_i && addr_i == `ADR_T5_LOW;
    assign wr_t5_mid   = wr_i && addr_i == `ADR_T5_MID;
    assign wr_t5_top   = wr_i && addr_i == `ADR_T5_TOP;

    // ============================================================
    // Timer 2
    logic [7:0]  t2_ctrl_reg;
    logic        t2_div_reg;
    logic [3:0]  t2_pre_reg;
    logic [15:0] t2_cnt_reg;
    logic [15:0] t2_rld_reg;
    t2_mode_e    t2_mode;
    logic        t2_run;
    logic        t2_exen;
    logic        t2_baud;
    logic        pre_tick;
    logic        t2_tick;
    logic        t2_wrap;
    logic        t2_trig;

    assign t2_run  = t2_ctrl_reg[`T2_TR];
    assign t2_exen = t2_ctrl_reg[`T2_EXEN];
    assign t2_baud = t2_ctrl_reg[`T2_RCLK] | t2_ctrl_reg[`T2_SERIAL_TX_CLOCK_SELECT];

    always_comb begin
        if (!t2_run) begin
            t2_mode = T2_STOPPED;
        end else if (t2_baud) begin
            t2_mode = T2_BAUD;
        end else if (t2_ctrl_reg[`T2_CPRL]) begin
            t2_mode = T2_CAPTURE;
        end else begin
            t2_mode = T2_RELOAD;
        end
    end

    // Prescaler, restarts whenever internal timing is not in use
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t2_pre_reg <= 4'h0;
        end else if (!t2_run || t2_ctrl_reg[`T2_CT] || pre_tick) begin
            t2_pre_reg <= 4'h0;
        end else begin
            t2_pre_reg <= t2_pre_reg + 4'h1;
        end
    end

    assign pre_tick = t2_pre_reg >= ((t2_div_reg ? `T2_DIV_FAST
                                                 : `T2_DIV_SLOW) - 4'h1);
    assign t2_tick  = t2_run && (t2_ctrl_reg[`T2_CT] ? ev_fall
                                                     : pre_tick);
    assign t2_wrap  = t2_tick && t2_cnt_reg == 16'hffff;
    assign t2_trig  = trig_fall && t2_exen;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t2_cnt_reg <= `RST_CNT16;
        end else if (wr_t2_lo) begin
            t2_cnt_reg[7:0] <= wdata_i;
        end else if (wr_t2_hi) begin
            t2_cnt_reg[15:8] <= wdata_i;
        end else if (t2_wrap && t2_mode != T2_CAPTURE) begin
            t2_cnt_reg <= t2_rld_reg;
        end else if (t2_trig && t2_mode == T2_RELOAD) begin
            t2_cnt_reg <= t2_rld_reg;
        end else if (t2_tick) begin
            t2_cnt_reg <= t2_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t2_rld_reg <= `RST_CNT16;
        end else if (wr_t2_rlo) begin
            t2_rld_reg[7:0] <= wdata_i;
        end else if (wr_t2_rhi) begin
            t2_rld_reg[15:8] <= wdata_i;
        end else if (t2_trig && t2_mode == T2_CAPTURE) begin
            t2_rld_reg <= t2_cnt_reg;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t2_div_reg <= 1'b0;
        end else if (wr_t2_div) begin
            t2_div_reg <= wdata_i[`T2_DIVB];
        end
    end

    // Hardware set wins over a same-cycle software clear
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t2_ctrl_reg <= `RST_BYTE;
        end else begin
            if (wr_t2_ctrl) begin
                t2_ctrl_reg <= wdata_i;
            end
            if (t2_wrap && !t2_baud) begin
                t2_ctrl_reg[`T2_TF] <= 1'b1;
            end
            if (t2_trig) begin
                t2_ctrl_reg[`T2_EXF] <= 1'b1;
            end
        end
    end

    // ============================================================
    // Timers 3 and 4
    logic [7:0]  t34_ctrl_reg;
    logic [15:0] t34_cnt_reg [2];
    logic [15:0] t34_rld_reg [2];
    logic [1:0]  t34_wrap;

    for (genvar i = 0; i < 2; i++) begin : g_t34
        localparam int B = `T34_T4 * i;
        localparam logic [15:0] A_LO = (i == 0) ? `ADR_T3_LOW
                                                : `ADR_T4_LOW;
        localparam logic [15:0] A_HI = (i == 0) ? `ADR_T3_HIGH
                                                : `ADR_T4_HIGH;
        logic        run;
        logic        reload;
        logic        wr_lo;
        logic        wr_hi;
        logic [23:0] nxt;

        assign run    = t34_ctrl_reg[B + `T34_TR];
        assign reload = t34_ctrl_reg[B + `T34_TM];
        assign wr_lo  = wr_i && addr_i == A_LO;
        assign wr_hi  = wr_i && addr_i == A_HI;
        assign nxt    = next_count({8'h00, t34_cnt_reg[i]},
                                   {8'h00, t34_rld_reg[i]},
                                   reload, 24'h00_ffff);
        assign t34_wrap[i] = run && t34_cnt_reg[i] == 16'hffff;

        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                t34_cnt_reg[i] <= `RST_CNT16;
            end else if (wr_lo && !reload) begin
                t34_cnt_reg[i][7:0] <= wdata_i;
            end else if (wr_hi && !reload) begin
                t34_cnt_reg[i][15:8] <= wdata_i;
            end else if (run) begin
                t34_cnt_reg[i] <= nxt[15:0];
            end
        end

        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                t34_rld_reg[i] <= `RST_CNT16;
            end else if (wr_lo && reload) begin
                t34_rld_reg[i][7:0] <= wdata_i;
            end else if (wr_hi && reload) begin
                t34_rld_reg[i][15:8] <= wdata_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t34_ctrl_reg <= `RST_BYTE;
        end else begin
            if (wr_t34_ctrl) begin
                t34_ctrl_reg <= wdata_i;
            end
            if (t34_wrap[0]) begin
                t34_ctrl_reg[`T34_TF] <= 1'b1;
            end
            if (t34_wrap[1]) begin
                t34_ctrl_reg[`T34_T4 + `T34_TF] <= 1'b1;
            end
        end
    end

    // ============================================================
    // Timer 5, stepped by edges of the selected oscillator
    logic [7:0]  t5_ctrl_reg;
    logic [23:0] t5_cnt_reg;
    logic [23:0] t5_rld_reg;
    logic        t5_run;
    logic        t5_reload;
    logic        t5_tick;
    logic        t5_wrap;
    logic        t5_cnt_wr;

    assign t5_run    = t5_ctrl_reg[`T5_TR];
    assign t5_reload = t5_ctrl_reg[`T5_TM];
    assign t5_tick   = t5_run && (t5_ctrl_reg[`T5_SELH] ? slow_rise
                                                        : fast_rise);
    assign t5_wrap   = t5_tick && t5_cnt_reg == 24'hff_ffff;
    assign t5_cnt_wr = wr_t5_lo || wr_t5_mid || wr_t5_top;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t5_cnt_reg <= `RST_CNT24;
        end else if (t5_cnt_wr && !t5_reload) begin
            if (wr_t5_lo) begin
                t5_cnt_reg[7:0] <= wdata_i;
            end
            if (wr_t5_mid) begin
                t5_cnt_reg[15:8] <= wdata_i;
            end
            if (wr_t5_top) begin
                t5_cnt_reg[23:16] <= wdata_i;
            end
        end else if (t5_tick) begin
            t5_cnt_reg <= next_count(t5_cnt_reg, t5_rld_reg, t5_reload,
                                     24'hff_ffff);
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t5_rld_reg <= `RST_CNT24;
        end else if (t5_reload) begin
            if (wr_t5_lo) begin
                t5_rld_reg[7:0] <= wdata_i;
            end
            if (wr_t5_mid) begin
                t5_rld_reg[15:8] <= wdata_i;
            end
            if (wr_t5_top) begin
                t5_rld_reg[23:16] <= wdata_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t5_ctrl_reg <= `RST_BYTE;
        end else begin
            if (wr_t5_ctrl) begin
                t5_ctrl_reg <= wdata_i & `T5_MASK;
            end
            if (t5_wrap) begin
                t5_ctrl_reg[`T5_TF] <= 1'b1;
            end
        end
    end

    // ============================================================
    // Read port, live values, no snapshot
    byte_t rd_val;

    always_comb begin
        unique case (addr_i)
            `ADR_T2_CTRL:   rd_val = t2_ctrl_reg;
            `ADR_T2_DIV:    rd_val = {7'h00, t2_div_reg};
            `ADR_T2_RLD_LO: rd_val = t2_rld_reg[7:0];
            `ADR_T2_RLD_HI: rd_val = t2_rld_reg[15:8];
            `ADR_T2_LOW:    rd_val = t2_cnt_reg[7:0];
            `ADR_T2_HIGH:   rd_val = t2_cnt_reg[15:8];
            `ADR_T34_CTRL:  rd_val = t34_ctrl_reg;
            `ADR_T3_LOW:    rd_val = t34_cnt_reg[0][7:0];
            `ADR_T3_HIGH:   rd_val = t34_cnt_reg[0][15:8];
            `ADR_T4_LOW:    rd_val = t34_cnt_reg[1][7:0];
            `ADR_T4_HIGH:   rd_val = t34_cnt_reg[1][15:8];
            `ADR_T5_CTRL:   rd_val = t5_ctrl_reg;
            `ADR_T5_LOW:    rd_val = t5_cnt_reg[7:0];
            `ADR_T5_MID:    rd_val = t5_cnt_reg[15:8];
            `ADR_T5_TOP:    rd_val = t5_cnt_reg[23:16];
            default:        rd_val = `RST_BYTE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= `RST_BYTE;
        end else begin
            rdata_o <= rd_i ? rd_val : `RST_BYTE;
        end
    end

    // ============================================================
    // Serial clocks and interrupt requests
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_rx_clk_o <= 1'b0;
            serial_tx_clk_o <= 1'b0;
            timer2_ovf_o    <= 1'b0;
        end else begin
            serial_rx_clk_o <= t2_ctrl_reg[`T2_RCLK] ? t2_wrap
                                                     : timer1_ovf_i;
            serial_tx_clk_o <= t2_ctrl_reg[`T2_SERIAL_TX_CLOCK_SELECT] ? t2_wrap
                                                     : timer1_ovf_i;
            timer2_ovf_o    <= t2_wrap;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer2_irq_o <= 1'b0;
            timer3_irq_o <= 1'b0;
            timer4_irq_o <= 1'b0;
            timer5_irq_o <= 1'b0;
        end else begin
            timer2_irq_o <= t2_ctrl_reg[`T2_TF] | t2_ctrl_reg[`T2_EXF];
            timer3_irq_o <= t34_ctrl_reg[`T34_TF]
                          & t34_ctrl_reg[`T34_IEN];
            timer4_irq_o <= t34_ctrl_reg[`T34_T4 + `T34_TF]
                          & t34_ctrl_reg[`T34_T4 + `T34_IEN];
            timer5_irq_o <= t5_ctrl_reg[`T5_TF] & t5_ctrl_reg[`T5_IEN];
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    logic t2_cnt_wr;
    assign t2_cnt_wr = wr_t2_lo || wr_t2_hi;

    a_t2_baud_flag: assert property (
        t2_baud && !wr_t2_ctrl && !t2_ctrl_reg[`T2_TF]
        |=> !t2_ctrl_reg[`T2_TF])
        else $error("timer 2 flag set in baud mode");

    a_t2_reload_val: assert property (
        t2_wrap && t2_mode == T2_RELOAD && !t2_cnt_wr && !wr_t2_rlo
        && !wr_t2_rhi |=> t2_cnt_reg == $past(t2_rld_reg)
        && t2_ctrl_reg[`T2_TF])
        else $error("timer 2 reload on overflow wrong");

    a_t2_hold_stop: assert property (
        !t2_run && !t2_cnt_wr |=> $stable(t2_cnt_reg))
        else $error("timer 2 moved while stopped");

    a_t2_edge_flag: assert property (
        t2_trig |=> t2_ctrl_reg[`T2_EXF])
        else $error("timer 2 edge flag not set");

    a_t2_trig_ignored: assert property (
        !t2_exen && !wr_t2_ctrl && !t2_ctrl_reg[`T2_EXF]
        |=> !t2_ctrl_reg[`T2_EXF])
        else $error("trigger honoured while disabled");

    a_t2_div_rate: assert property (
        t2_run && !t2_ctrl_reg[`T2_CT] && !t2_div_reg && pre_tick
        && !wr_t2_ctrl && !wr_t2_div
        |=> !pre_tick [*8])
        else $error("timer 2 prescale too fast");

    a_t3_stopped: assert property (
        !t34_ctrl_reg[`T34_TR] && !wr_i |=> $stable(t34_cnt_reg[0]))
        else $error("timer 3 moved while stopped");

    a_t3_flag_set: assert property (
        t34_wrap[0] |=> t34_ctrl_reg[`T34_TF] ##1 timer3_irq_o
        || !t34_ctrl_reg[`T34_IEN])
        else $error("timer 3 overflow not flagged");

    a_t5_free_wrap: assert property (
        t5_wrap && !t5_reload && !t5_cnt_wr
        |=> t5_cnt_reg == `RST_CNT24 && t5_ctrl_reg[`T5_TF])
        else $error("timer 5 free-run wrap wrong");

    a_rx_clk_sel: assert property (
        ##1 serial_rx_clk_o == ($past(t2_ctrl_reg[`T2_RCLK])
        ? $past(t2_wrap) : $past(timer1_ovf_i)))
        else $error("receive clock source wrong");

endmodule : sys_timers

/* File: bench/serial_port_model.sv */
`timescale 1ns/1ps
// ============================================================
// Serial port side: sends timer 1 ticks, counts baud pulses
module serial_port_model (
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    input  wire logic t1_en_i,
    input  wire logic rx_clk_i,
    input  wire logic tx_clk_i,
    input  wire logic t2_ovf_i,
    output logic      timer1_ovf_o,
    output int        cnt_o [4]
);
    int div_reg;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_reg      <= 0;
            timer1_ovf_o <= 1'b0;
            cnt_o        <= '{default: 0};
        end else begin
            div_reg      <= (div_reg == 9) ? 0 : div_reg + 1;
            timer1_ovf_o <= t1_en_i && (div_reg == 9);
            cnt_o[0]     <= cnt_o[0] + int'(rx_clk_i);
            cnt_o[1]     <= cnt_o[1] + int'(tx_clk_i);
            cnt_o[2]     <= cnt_o[2] + int'(timer1_ovf_o);
            cnt_o[3]     <= cnt_o[3] + int'(t2_ovf_i);
        end
    end
endmodule : serial_port_model

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`include "sys_timers_params.svh"
// ============================================================
// Timer block bench
module tb_top;
    import sys_timers_pkg::*;
    logic        clk   = 1'b0;
    logic        rstn  = 1'b0;
    logic [15:0] addr  = '0;
    byte_t       wdata = '0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [2:0]  pins  = '0;
    logic        fosc  = 1'b0;
    logic        t1_en = 1'b1;
    byte_t       rdata;
    logic        t1ovf, rxc, txc, ovf2;
    logic [3:0]  irq;
    int          cnt [4];
    int          d [4];
    int          miscompares = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          t;
    logic [31:0] rows [14] = '{32'h00cf_5555, 32'h00ae_1200, 32'h00cf_0000,
        32'h00ae_3434, 32'h00ad_7777, 32'h00b0_aa00, 32'ha003_f7f1,
        32'ha003_0000, 32'ha004_9a9a, 32'ha003_1010, 32'ha005_5600,
        32'h00c8_0303, 32'h00c8_0000, 32'h00c9_0101};

    sys_timers i_sys_timers (.core_clk_i(clk), .rstn_i(rstn), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .timer2_event_pin_i(pins[0]), .timer2_trigger_input_i(pins[1]),
        .fast_osc_i(fosc), .slow_osc_i(pins[2]), .timer1_ovf_i(t1ovf),
        .serial_rx_clk_o(rxc), .serial_tx_clk_o(txc), .timer2_ovf_o(ovf2),
        .timer2_irq_o(irq[0]), .timer3_irq_o(irq[1]),
        .timer4_irq_o(irq[2]), .timer5_irq_o(irq[3]));
    serial_port_model i_serial_port_model (.core_clk_i(clk), .rstn_i(rstn),
        .t1_en_i(t1_en), .rx_clk_i(rxc), .tx_clk_i(txc), .t2_ovf_i(ovf2),
        .timer1_ovf_o(t1ovf), .cnt_o(cnt));

    initial forever #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // Fast oscillator runs free; slow one is pulsed by hand
    always begin
        repeat (3) @(posedge clk);
        fosc <= ~fosc;
    end

    // ========================================================
    // Bus, pin and compare tasks
    task automatic conclude();
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [15:0] a, input byte_t v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [15:0] a, input byte_t e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(rdata, e);
    endtask : rd_chk
    task automatic pin(input int k);
        @(posedge clk);
        pins[k] <= 1'b1;
        repeat (4) @(posedge clk);
        pins[k] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : pin
    task automatic wait_hi(input int i);
        int         n;
        logic [4:0] v;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            v = {irq, ovf2};
        end while (v[i] !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            miscompares++;
            conclude();
        end
    endtask : wait_hi
    task automatic window(input bit fixed);
        int s [4];
        if (!fixed) wait_hi(0);
        repeat (fixed ? 320 : 3) @(posedge clk);
        s = cnt;
        if (!fixed) wait_hi(0);
        repeat (fixed ? 320 : 3) @(posedge clk);
        foreach (d[k]) d[k] = cnt[k] - s[k];
    endtask : window

    // ========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[r]) rd_chk(rows[r][31:16], 8'h00);
        foreach (rows[r]) begin
            wr_reg(rows[r][31:16], rows[r][15:8]);
            rd_chk(rows[r][31:16], rows[r][7:0]);
        end
        wr_reg(`ADR_T3_HIGH, 8'hff);
        wr_reg(`ADR_T3_LOW, 8'hf0);
        wr_reg(`ADR_T34_CTRL, 8'h03);
        wait_hi(2);
        rd_chk(`ADR_T34_CTRL, 8'h0b);
        wr_reg(`ADR_T34_CTRL, 8'h08);
        rd_chk(`ADR_T3_HIGH, 8'h00);
        check(irq[1], 1'b0);
        wr_reg(`ADR_T4_HIGH, 8'hff);
        wr_reg(`ADR_T4_LOW, 8'hf0);
        wr_reg(`ADR_T34_CTRL, 8'h40);
        wr_reg(`ADR_T4_HIGH, 8'h80);
        wr_reg(`ADR_T4_LOW, 8'h00);
        wr_reg(`ADR_T34_CTRL, 8'h70);
        wait_hi(3);
        rd_chk(`ADR_T34_CTRL, 8'hf0);
        wr_reg(`ADR_T34_CTRL, 8'h40);
        rd_chk(`ADR_T4_HIGH, 8'h80);
        wr_reg(`ADR_T2_RLD_LO, 8'hf0);
        wr_reg(`ADR_T2_RLD_HI, 8'hff);
        wr_reg(`ADR_T2_HIGH, 8'hff);
        wr_reg(`ADR_T2_CTRL, 8'h04);
        wait_hi(0);
        t = cyc;
        wait_hi(0);
        check(cyc - t, 64);
        rd_chk(`ADR_T2_CTRL, 8'h84);
        wr_reg(`ADR_T2_DIV, 8'h00);
        wait_hi(0);
        t = cyc;
        wait_hi(0);
        check(cyc - t, 192);
        window(1'b1);
        check({d[0], d[1]}, {d[2], d[2]});
        t1_en <= 1'b0;
        wr_reg(`ADR_T2_CTRL, 8'h24);
        window(1'b0);
        check({d[0], d[1]}, {32'd1, 32'd0});
        check(d[3], 32'd1);
        wr_reg(`ADR_T2_CTRL, 8'h14);
        window(1'b0);
        check({d[0], d[1]}, {32'd0, 32'd1});
        rd_chk(`ADR_T2_CTRL, 8'h14);
        wr_reg(`ADR_T2_CTRL, 8'h05);
        pin(1);
        rd_chk(`ADR_T2_CTRL, 8'h05);
        rd_chk(`ADR_T2_RLD_HI, 8'hff);
        wr_reg(`ADR_T2_HIGH, 8'h00);
        wr_reg(`ADR_T2_LOW, 8'h00);
        wr_reg(`ADR_T2_CTRL, 8'h0d);
        pin(1);
        rd_chk(`ADR_T2_CTRL, 8'h4d);
        check(irq[0], 1'b1);
        rd_chk(`ADR_T2_RLD_HI, 8'h00);
        wr_reg(`ADR_T2_CTRL, 8'h00);
        wr_reg(`ADR_T2_LOW, 8'h00);
        wr_reg(`ADR_T2_CTRL, 8'h06);
        repeat (5) pin(0);
        wr_reg(`ADR_T2_CTRL, 8'h00);
        rd_chk(`ADR_T2_LOW, 8'h05);
        wr_reg(`ADR_T5_CTRL, 8'h00);
        wr_reg(`ADR_T5_MID, 8'h00);
        wr_reg(`ADR_T5_LOW, 8'h00);
        wr_reg(`ADR_T5_CTRL, 8'h48);
        repeat (3) pin(2);
        wr_reg(`ADR_T5_CTRL, 8'h40);
        rd_chk(`ADR_T5_LOW, 8'h03);
        foreach (rows[r]) if (r < 3) wr_reg(16'ha004 + 16'(r), 8'hff);
        wr_reg(`ADR_T5_CTRL, 8'h49);
        pin(2);
        wait_hi(4);
        rd_chk(`ADR_T5_TOP, 8'h00);
        rd_chk(`ADR_T5_CTRL, 8'hc9);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(`ADR_T5_CTRL, 8'h00);
        check(irq, 4'h0);
        conclude();
    end
endmodule : tb_top
